//--- rtl/dsof_top.sv
// Drive status flag generator with selectable output terminals and alarm relay
`timescale 1ns/1ps

module dsof_top (
	input wire logic mclk_in, // 40 MHz clock
	input wire logic reset_n_in, // Synchronous reset, active low
	input wire logic [dsof_pkg::ADDR_W-1:0] addr_in, // Register address
	input wire logic [dsof_pkg::DATA_W-1:0] wr_data_in, // Register write data
	input wire logic wr_en_in, // Write strobe
	input wire logic rd_en_in, // Read strobe
	output logic [dsof_pkg::DATA_W-1:0] rd_data_out, // Read data, cycle after strobe
	input wire logic [7:0] fan_speed_pct_in, // Fan speed, percent of full
	input wire logic [7:0] heatsink_temp_in, // Heat sink temperature, degrees C
	input wire logic [7:0] out_current_in, // Output current, hundredths of rated
	input wire logic const_speed_in, // Motor at constant speed
	input wire logic main_power_ok_in, // Main power present
	input wire logic trip_active_in, // Drive is in a trip state
	input wire logic trip_event_in, // One-cycle trip pulse
	input wire logic [7:0] trip_code_in, // Error number with trip pulse
	input wire logic fault_reset_in, // Clears major failure
	input wire logic forward_run_command_in, // Forward command terminal
	input wire logic reverse_run_command_in, // Reverse command terminal
	output logic motor_fwd_out, // Drive motor forward
	output logic motor_rev_out, // Drive motor reverse
	output logic [dsof_pkg::NUM_TERM-1:0] terminal_out, // Programmable terminals
	output logic relay_out, // Alarm relay
	output logic irq_out // Interrupt, level
);
	import dsof_pkg::*;

	typedef struct packed {
		logic [NUM_SEL-1:0][7:0] sel;
		logic [7:0] fan_control_setting;
		logic [7:0] heatsink_warn_level;
		logic [7:0] low_current_mode_setting;
		logic [7:0] low_current_threshold;
		logic [7:0] run_command_source;
		logic [1:0] sw_cmd;
		logic blocked;
		dsof_run_t run;
		logic [FLAG_W-1:0] flags;
		logic [FLAG_W-1:0] status;
		logic [FLAG_W-1:0] mask;
		logic major;
		logic [NUM_TERM-1:0] term;
		logic relay;
		logic [DATA_W-1:0] rd_data;
	} dsof_state_t;

	localparam dsof_state_t RST_STATE = '{
		sel: RST_SEL,
		fan_control_setting: RST_FAN_CTL,
		heatsink_warn_level: RST_HEAT_WARN,
		low_current_mode_setting: RST_LOC_MODE,
		low_current_threshold: RST_LOC_THR,
		run_command_source: RST_RUN_SRC,
		sw_cmd: 2'h0,
		blocked: 1'b0,
		run: DSOF_STOP,
		flags: 8'h00,
		status: 8'h00,
		mask: RST_MASK,
		major: 1'b0,
		term: 5'h00,
		relay: 1'b0,
		rd_data: 8'h00
	};

	dsof_state_t st;
	dsof_state_t next_st;

	// Unknown codes drive the output low
	function automatic logic select_flag(input logic [7:0] code, input logic [FLAG_W-1:0] f);
		case (code)
			CODE_FAN: select_flag = f[FLAG_FAN];
			CODE_START: select_flag = f[FLAG_START];
			CODE_OHEAT: select_flag = f[FLAG_OHEAT];
			CODE_LOWCUR: select_flag = f[FLAG_LOWCUR];
			CODE_READY: select_flag = f[FLAG_READY];
			CODE_FWD: select_flag = f[FLAG_FWD];
			CODE_REV: select_flag = f[FLAG_REV];
			CODE_MAJOR: select_flag = f[FLAG_MAJOR];
			default: select_flag = 1'b0;
		endcase
	endfunction : select_flag

	function automatic logic [7:0] clamp(input logic [7:0] v, input logic [7:0] lim);
		clamp = (v > lim) ? lim : v;
	endfunction : clamp

	logic fwd_cmd;
	logic rev_cmd;
	logic any_cmd;
	logic ready;
	logic major_trip;
	logic running;
	logic loc_gate;
	logic [FLAG_W-1:0] next_flags;

	always_comb begin
		next_st = st;
		// Software commands steer the motor only when chosen as run source
		fwd_cmd = (st.run_command_source == RUN_SRC_REG) ? st.sw_cmd[0] : forward_run_command_in;
		rev_cmd = (st.run_command_source == RUN_SRC_REG) ? st.sw_cmd[1] : reverse_run_command_in;
		any_cmd = fwd_cmd | rev_cmd;
		ready = main_power_ok_in & ~trip_active_in & ~st.major;
		major_trip = trip_event_in & (trip_code_in == TRIP_CT || trip_code_in == TRIP_CPU ||
			trip_code_in == TRIP_GND || trip_code_in == TRIP_FANTEMP ||
			trip_code_in == TRIP_GATECOM || trip_code_in == TRIP_MAIN);

		// Latch a command seen while not ready until it is released
		if (any_cmd && !ready) begin
			next_st.blocked = 1'b1;
		end else if (!any_cmd) begin
			next_st.blocked = 1'b0;
		end

		if (!ready || next_st.blocked) begin
			next_st.run = DSOF_STOP;
		end else if (fwd_cmd && rev_cmd) begin
			next_st.run = DSOF_STOP;
		end else if (fwd_cmd) begin
			next_st.run = DSOF_RUN_FWD;
		end else if (rev_cmd) begin
			next_st.run = DSOF_RUN_REV;
		end else begin
			next_st.run = DSOF_STOP;
		end
		running = (next_st.run != DSOF_STOP);

		// Trip wins over a simultaneous fault reset
		if (major_trip) begin
			next_st.major = 1'b1;
		end else if (fault_reset_in) begin
			next_st.major = 1'b0;
		end

		case (st.low_current_mode_setting)
			LOWCUR_CONST: loc_gate = running & const_speed_in;
			default: loc_gate = running;
		endcase

		next_flags = '0;
		next_flags[FLAG_FAN] = (fan_speed_pct_in <= FAN_SLOW_PCT) &&
			(st.fan_control_setting != FAN_CTL_NOWARN);
		next_flags[FLAG_START] = forward_run_command_in | reverse_run_command_in |
			(|st.sw_cmd);
		next_flags[FLAG_OHEAT] = heatsink_temp_in > st.heatsink_warn_level;
		next_flags[FLAG_LOWCUR] = (out_current_in <= st.low_current_threshold) & loc_gate;
		next_flags[FLAG_READY] = ready;
		next_flags[FLAG_FWD] = (next_st.run == DSOF_RUN_FWD);
		next_flags[FLAG_REV] = (next_st.run == DSOF_RUN_REV);
		next_flags[FLAG_MAJOR] = next_st.major;
		next_st.flags = next_flags;

		for (int i = 0; i < NUM_TERM; i++) begin
			next_st.term[i] = select_flag(st.sel[i], next_flags);
		end
		next_st.relay = select_flag(st.sel[NUM_SEL-1], next_flags);

		// Rising flags set sticky bits; a set in the clear cycle wins
		next_st.status = st.status;
		if (wr_en_in && addr_in == REG_IRQ_STAT) begin
			next_st.status = st.status & ~wr_data_in;
		end
		next_st.status = next_st.status | (next_flags & ~st.flags);

		if (wr_en_in) begin
			if (addr_in <= REG_RELAY_SEL) begin
				next_st.sel[addr_in[2:0]] = wr_data_in;
			end
			case (addr_in)
				REG_FAN_CTL: next_st.fan_control_setting = wr_data_in;
				REG_HEAT_WARN: next_st.heatsink_warn_level = clamp(wr_data_in, HEAT_MAX_C);
				REG_LOC_MODE: next_st.low_current_mode_setting = wr_data_in;
				REG_LOC_THR: next_st.low_current_threshold = clamp(wr_data_in, LOWCUR_MAX);
				REG_RUN_SRC: next_st.run_command_source = wr_data_in;
				REG_SW_CMD: next_st.sw_cmd = wr_data_in[1:0];
				REG_IRQ_MASK: next_st.mask = wr_data_in;
				default: ;
			endcase
		end

		next_st.rd_data = 8'h00;
		if (rd_en_in) begin
			if (addr_in <= REG_RELAY_SEL) begin
				next_st.rd_data = st.sel[addr_in[2:0]];
			end
			case (addr_in)
				REG_FAN_CTL: next_st.rd_data = st.fan_control_setting;
				REG_HEAT_WARN: next_st.rd_data = st.heatsink_warn_level;
				REG_LOC_MODE: next_st.rd_data = st.low_current_mode_setting;
				REG_LOC_THR: next_st.rd_data = st.low_current_threshold;
				REG_RUN_SRC: next_st.rd_data = st.run_command_source;
				REG_SW_CMD: next_st.rd_data = {6'h00, st.sw_cmd};
				REG_FLAGS: next_st.rd_data = st.flags;
				REG_LIFE: next_st.rd_data = {7'h00, st.flags[FLAG_FAN]};
				REG_IRQ_STAT: next_st.rd_data = st.status;
				REG_IRQ_MASK: next_st.rd_data = st.mask;
				default: ;
			endcase
		end
	end

	always_ff @(posedge mclk_in) begin
		if (!reset_n_in) begin
			st <= RST_STATE;
		end else begin
			st <= next_st;
		end
	end

	assign rd_data_out = st.rd_data;
	assign motor_fwd_out = (st.run == DSOF_RUN_FWD);
	assign motor_rev_out = (st.run == DSOF_RUN_REV);
	assign terminal_out = st.term;
	assign relay_out = st.relay;
	assign irq_out = |(st.status & st.mask);

	default clocking dsof_cb @(posedge mclk_in);
	endclocking
	default disable iff (!reset_n_in);

	sequence s_cmd_while_not_ready;
		!ready && forward_run_command_in && !reverse_run_command_in &&
			st.run_command_source != RUN_SRC_REG;
	endsequence

	sequence s_cmd_held;
		forward_run_command_in [*3];
	endsequence

	a_fan_slow_flag: assert property (
		(fan_speed_pct_in <= FAN_SLOW_PCT && st.fan_control_setting != FAN_CTL_NOWARN)
		|=> st.flags[FLAG_FAN])
		else $error("fan slowdown flag missing");

	a_fan_ctl_mute: assert property (
		(st.fan_control_setting == FAN_CTL_NOWARN) |=> !st.flags[FLAG_FAN])
		else $error("fan flag raised while muted");

	a_term_fan_code: assert property (
		(st.sel[0] == CODE_FAN && reset_n_in) |=> (terminal_out[0] == st.flags[FLAG_FAN]))
		else $error("terminal 0 does not follow fan flag");

	a_start_contact: assert property (
		(forward_run_command_in || reverse_run_command_in) |=> st.flags[FLAG_START])
		else $error("start contact flag missing");

	a_both_cmd_stop: assert property (
		(fwd_cmd && rev_cmd) |=> (!motor_fwd_out && !motor_rev_out))
		else $error("motor driven with both commands");

	a_heat_warn: assert property (
		(heatsink_temp_in > st.heatsink_warn_level) |=> st.flags[FLAG_OHEAT])
		else $error("overtemperature flag missing");

	a_loc_const_gate: assert property (
		(st.low_current_mode_setting == LOWCUR_CONST && !const_speed_in)
		|=> !st.flags[FLAG_LOWCUR])
		else $error("low current flag outside constant speed");

	a_ready_power: assert property (
		!main_power_ok_in |=> !st.flags[FLAG_READY] ##0 !motor_fwd_out)
		else $error("ready without main power");

	a_not_ready_ignore: assert property (
		s_cmd_while_not_ready ##1 s_cmd_held |-> !motor_fwd_out)
		else $error("command taken while not ready");

	a_rotation_flags: assert property (
		motor_fwd_out |-> (st.flags[FLAG_FWD] && !st.flags[FLAG_REV]))
		else $error("rotation flags disagree with drive");

	a_major_trip: assert property (
		(trip_event_in && trip_code_in == TRIP_GND) |=> (st.flags[FLAG_MAJOR] && !ready))
		else $error("major failure not flagged");

	a_irq_level: assert property (
		(|(st.status & st.mask)) |-> irq_out ##1 (irq_out || $past(wr_en_in)))
		else $error("interrupt dropped without clear");

	a_fan_flag_clear: assert property (
		(fan_speed_pct_in > FAN_SLOW_PCT) |=> !st.flags[FLAG_FAN])
		else $error("fan slowdown flag without slow fan");

	a_life_readout: assert property (
		(rd_en_in && addr_in == REG_LIFE)
		|=> (rd_data_out == {7'h00, $past(st.flags[FLAG_FAN])}))
		else $error("life check readout disagrees with fan flag");

	a_start_drop: assert property (
		(!forward_run_command_in && !reverse_run_command_in && st.sw_cmd == 2'h0)
		|=> !st.flags[FLAG_START])
		else $error("start contact flag without a command");

	a_heat_clear: assert property (
		(heatsink_temp_in <= st.heatsink_warn_level) |=> !st.flags[FLAG_OHEAT])
		else $error("overtemperature flag below warning level");

	a_heat_clamp: assert property (
		st.heatsink_warn_level <= HEAT_MAX_C)
		else $error("warning level above its range");

	a_loc_level: assert property (
		(out_current_in > st.low_current_threshold) |=> !st.flags[FLAG_LOWCUR])
		else $error("low current flag above threshold");

	a_loc_thr_clamp: assert property (
		st.low_current_threshold <= LOWCUR_MAX)
		else $error("low current threshold above its range");

	a_loc_raise: assert property (
		(out_current_in <= st.low_current_threshold && running &&
			st.low_current_mode_setting != LOWCUR_CONST) |=> st.flags[FLAG_LOWCUR])
		else $error("low current flag missing while running");

	a_loc_running: assert property (
		st.flags[FLAG_LOWCUR] |-> (motor_fwd_out || motor_rev_out))
		else $error("low current flag while stopped");

	a_ready_flag: assert property (
		(main_power_ok_in && !trip_active_in && !st.major) |=> st.flags[FLAG_READY])
		else $error("ready flag missing");

	a_blocked_hold: assert property (
		(st.blocked && (fwd_cmd || rev_cmd)) |=> (!motor_fwd_out && !motor_rev_out))
		else $error("held command taken after ready returned");

	a_rev_flags: assert property (
		motor_rev_out |-> (st.flags[FLAG_REV] && !st.flags[FLAG_FWD]))
		else $error("reverse flag disagrees with drive");

	a_stop_flags: assert property (
		(!motor_fwd_out && !motor_rev_out) |-> (!st.flags[FLAG_FWD] && !st.flags[FLAG_REV]))
		else $error("rotation flag raised while stopped");

	a_major_hold: assert property (
		(st.flags[FLAG_MAJOR] && !fault_reset_in) |=> st.flags[FLAG_MAJOR])
		else $error("major failure flag dropped without fault reset");

	a_minor_quiet: assert property (
		(!major_trip && !st.major) |=> !st.flags[FLAG_MAJOR])
		else $error("major failure flag without a listed trip");

	a_relay_major: assert property (
		(st.sel[NUM_SEL-1] == CODE_MAJOR) |=> (relay_out == st.flags[FLAG_MAJOR]))
		else $error("relay does not follow major failure flag");

	a_term_ready: assert property (
		(st.sel[4] == CODE_READY) |=> (terminal_out[4] == st.flags[FLAG_READY]))
		else $error("terminal 4 does not follow ready flag");

	// Must see the reset cycles themselves, so the default disable is overridden
	a_reset_outputs: assert property (disable iff (1'b0)
		!reset_n_in |=> (terminal_out == 5'h00 && !relay_out && !irq_out &&
			!motor_fwd_out && !motor_rev_out && rd_data_out == 8'h00))
		else $error("outputs active after a reset cycle");

	a_status_sticky: assert property (
		(st.status[FLAG_OHEAT] && !(wr_en_in && addr_in == REG_IRQ_STAT))
		|=> st.status[FLAG_OHEAT])
		else $error("status bit lost without a clear");

	a_status_set: assert property (
		$rose(st.flags[FLAG_OHEAT]) |-> st.status[FLAG_OHEAT])
		else $error("rising flag did not set its status bit");

endmodule : dsof_top

//--- rtl/dsof_pkg.sv
// Package for the drive status output flag block: codes, offsets, reset values
package dsof_pkg;

	localparam int FLAG_W = 8;
	localparam int NUM_TERM = 5;
	localparam int NUM_SEL = 6;
	localparam int ADDR_W = 5;
	localparam int DATA_W = 8;

	// Flag bit positions
	localparam int FLAG_FAN = 0;
	localparam int FLAG_START = 1;
	localparam int FLAG_OHEAT = 2;
	localparam int FLAG_LOWCUR = 3;
	localparam int FLAG_READY = 4;
	localparam int FLAG_FWD = 5;
	localparam int FLAG_REV = 6;
	localparam int FLAG_MAJOR = 7;

	// Function-select codes (decimal 40, 41, 42, 43, 50, 51, 52, 53)
	localparam logic [7:0] CODE_FAN = 8'h28;
	localparam logic [7:0] CODE_START = 8'h29;
	localparam logic [7:0] CODE_OHEAT = 8'h2A;
	localparam logic [7:0] CODE_LOWCUR = 8'h2B;
	localparam logic [7:0] CODE_READY = 8'h32;
	localparam logic [7:0] CODE_FWD = 8'h33;
	localparam logic [7:0] CODE_REV = 8'h34;
	localparam logic [7:0] CODE_MAJOR = 8'h35;

	// Hardware trip codes that count as major failure (10, 11, 14, 20, 23, 25)
	localparam logic [7:0] TRIP_CT = 8'h0A;
	localparam logic [7:0] TRIP_CPU = 8'h0B;
	localparam logic [7:0] TRIP_GND = 8'h0E;
	localparam logic [7:0] TRIP_FANTEMP = 8'h14;
	localparam logic [7:0] TRIP_GATECOM = 8'h17;
	localparam logic [7:0] TRIP_MAIN = 8'h19;

	// Thresholds and setting values
	localparam logic [7:0] FAN_SLOW_PCT = 8'h4B;
	localparam logic [7:0] FAN_CTL_NOWARN = 8'h01;
	localparam logic [7:0] HEAT_MAX_C = 8'hC8;
	localparam logic [7:0] LOWCUR_MAX = 8'hC8;
	localparam logic [7:0] LOWCUR_ALWAYS = 8'h00;
	localparam logic [7:0] LOWCUR_CONST = 8'h01;
	localparam logic [7:0] RUN_SRC_REG = 8'h01;

	// Register offsets
	localparam logic [ADDR_W-1:0] REG_SEL0 = 5'h00;
	localparam logic [ADDR_W-1:0] REG_RELAY_SEL = 5'h05;
	localparam logic [ADDR_W-1:0] REG_FAN_CTL = 5'h06;
	localparam logic [ADDR_W-1:0] REG_HEAT_WARN = 5'h07;
	localparam logic [ADDR_W-1:0] REG_LOC_MODE = 5'h08;
	localparam logic [ADDR_W-1:0] REG_LOC_THR = 5'h09;
	localparam logic [ADDR_W-1:0] REG_RUN_SRC = 5'h0A;
	localparam logic [ADDR_W-1:0] REG_SW_CMD = 5'h0B;
	localparam logic [ADDR_W-1:0] REG_FLAGS = 5'h0C;
	localparam logic [ADDR_W-1:0] REG_LIFE = 5'h0D;
	localparam logic [ADDR_W-1:0] REG_IRQ_STAT = 5'h0E;
	localparam logic [ADDR_W-1:0] REG_IRQ_MASK = 5'h0F;

	// Reset values
	localparam logic [5:0][7:0] RST_SEL = {CODE_MAJOR, CODE_READY, CODE_LOWCUR,
		CODE_OHEAT, CODE_START, CODE_FAN};
	localparam logic [7:0] RST_FAN_CTL = 8'h00;
	localparam logic [7:0] RST_HEAT_WARN = 8'h78;
	localparam logic [7:0] RST_LOC_MODE = 8'h00;
	localparam logic [7:0] RST_LOC_THR = 8'h50;
	localparam logic [7:0] RST_RUN_SRC = 8'h00;
	localparam logic [7:0] RST_MASK = 8'h00;

	typedef enum logic [1:0] {DSOF_STOP, DSOF_RUN_FWD, DSOF_RUN_REV} dsof_run_t;

endpackage : dsof_pkg

//--- testbench/dsof_ctrl_model.sv
// Controller model: run command contacts and terminal readback
`timescale 1ns/1ps

module dsof_ctrl_model (
	input wire logic mclk_in, // Shared clock
	input wire logic fwd_req_in, // Bench asks for forward
	input wire logic rev_req_in, // Bench asks for reverse
	input wire logic [4:0] terminal_in, // Drive terminals
	input wire logic relay_in, // Drive relay
	output logic forward_run_command_out, // Forward contact
	output logic reverse_run_command_out, // Reverse contact
	output logic [5:0] seen_out // Latched relay and terminals
);
	// Scanned like a PLC, so everything lands one clock late
	always_ff @(posedge mclk_in) begin
		forward_run_command_out <= fwd_req_in;
		reverse_run_command_out <= rev_req_in;
		seen_out <= {relay_in, terminal_in};
	end
endmodule : dsof_ctrl_model

//--- testbench/drive_status_output_flags_bench.sv
// Self-checking bench for the drive status flag block
`timescale 1ns/1ps

module drive_status_output_flags_bench;
	import dsof_pkg::*;
	localparam logic [0:7][7:0] CODES = {CODE_FAN, CODE_START, CODE_OHEAT, CODE_LOWCUR,
		CODE_READY, CODE_FWD, CODE_REV, CODE_MAJOR};
	localparam logic [0:6][7:0] TRIPS = {TRIP_CT, TRIP_CPU, TRIP_GND, TRIP_FANTEMP,
		TRIP_GATECOM, TRIP_MAIN, 8'h0C};
	localparam logic [7:0] RUN_FLAGS = 8'h33;
	logic mclk_in = 1'b0;
	logic reset_n_in = 1'b0;
	logic [4:0] addr = 5'h00;
	logic [7:0] wdat = 8'h00, fan = 8'h64, temp = 8'h19, cur = 8'hC8, tcode = 8'h00;
	logic wr = 1'b0, rd = 1'b0, cspd = 1'b0, pwr = 1'b1, tact = 1'b0, tev = 1'b0;
	logic frst = 1'b0, fq = 1'b0, rq = 1'b0;
	logic fcmd, rcmd, mf, mr, relay, irq;
	logic [7:0] rdat, v;
	logic [4:0] term;
	logic [5:0] seen;
	int err_count = 0;
	int check_count = 0;

	dsof_top i_dsof_top (.mclk_in(mclk_in), .reset_n_in(reset_n_in), .addr_in(addr),
		.wr_data_in(wdat), .wr_en_in(wr), .rd_en_in(rd), .rd_data_out(rdat),
		.fan_speed_pct_in(fan), .heatsink_temp_in(temp), .out_current_in(cur),
		.const_speed_in(cspd), .main_power_ok_in(pwr), .trip_active_in(tact),
		.trip_event_in(tev), .trip_code_in(tcode), .fault_reset_in(frst),
		.forward_run_command_in(fcmd), .reverse_run_command_in(rcmd),
		.motor_fwd_out(mf), .motor_rev_out(mr), .terminal_out(term), .relay_out(relay),
		.irq_out(irq));
	dsof_ctrl_model i_dsof_ctrl_model (.mclk_in(mclk_in), .fwd_req_in(fq), .rev_req_in(rq),
		.terminal_in(term), .relay_in(relay), .forward_run_command_out(fcmd),
		.reverse_run_command_out(rcmd), .seen_out(seen));

	initial begin
		forever #12.5 mclk_in = ~mclk_in;
	end

	task automatic chk(input logic [7:0] s, input logic [7:0] e);
		check_count++;
		if (s !== e) begin
			err_count++;
			$display("unexpected at %0t ns: seen %h expected %h", $time, s, e);
		end
	endtask : chk

	task automatic settle();
		repeat (3) @(posedge mclk_in);
		@(negedge mclk_in);
	endtask : settle

	task automatic wr_reg(input logic [4:0] a, input logic [7:0] d);
		@(posedge mclk_in);
		addr <= a;
		wdat <= d;
		wr <= 1'b1;
		@(posedge mclk_in);
		wr <= 1'b0;
	endtask : wr_reg

	// Read data only stands for the one cycle after the strobe
	task automatic rd_reg(input logic [4:0] a);
		@(posedge mclk_in);
		addr <= a;
		rd <= 1'b1;
		@(posedge mclk_in);
		rd <= 1'b0;
		@(negedge mclk_in);
		v = rdat;
	endtask : rd_reg

	task automatic done(input string s);
		$display("test %s finished", s);
	endtask : done

	task automatic close_out();
		$display("checks %0d mismatches %0d", check_count, err_count);
		if (err_count == 0 && check_count > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask : close_out

	initial begin
		repeat (4000) @(posedge mclk_in);
		err_count++;
		close_out();
	end

	initial begin
		repeat (2) @(posedge mclk_in);
		reset_n_in <= 1'b1;
		@(negedge mclk_in);
		chk({mf | mr, relay, irq, term}, 8'h00);
		settle();
		chk(8'(term), 8'h10);
		for (int i = 0; i < 6; i++) begin
			rd_reg(5'(i));
			chk(v, RST_SEL[i]);
		end
		rd_reg(5'h10);
		chk(v, 8'h00);
		done("reset");
		@(posedge mclk_in) fan <= FAN_SLOW_PCT;
		settle();
		chk(8'(term), 8'h11);
		rd_reg(REG_LIFE);
		chk(8'(v[0]), 8'h01);
		@(posedge mclk_in) fan <= 8'h4C;
		settle();
		chk(8'(term), 8'h10);
		@(posedge mclk_in) fan <= 8'h00;
		wr_reg(REG_FAN_CTL, FAN_CTL_NOWARN);
		settle();
		chk(8'(term), 8'h10);
		wr_reg(REG_FAN_CTL, 8'h00);
		settle();
		chk(8'(term), 8'h11);
		done("fan");
		@(posedge mclk_in) temp <= RST_HEAT_WARN;
		settle();
		chk(8'(term[2]), 8'h00);
		@(posedge mclk_in) temp <= 8'h79;
		settle();
		chk(8'(term[2]), 8'h01);
		wr_reg(REG_HEAT_WARN, HEAT_MAX_C);
		settle();
		chk(8'(term[2]), 8'h00);
		@(posedge mclk_in) temp <= 8'h19;
		done("heat");
		@(posedge mclk_in) fq <= 1'b1;
		settle();
		chk({6'h00, mf, mr}, 8'h02);
		rd_reg(REG_FLAGS);
		chk(v, RUN_FLAGS);
		@(posedge mclk_in) cur <= RST_LOC_THR;
		settle();
		chk(8'(term[3]), 8'h01);
		@(posedge mclk_in) cur <= 8'h51;
		settle();
		chk(8'(term[3]), 8'h00);
		@(posedge mclk_in) cur <= 8'h00;
		wr_reg(REG_LOC_MODE, LOWCUR_CONST);
		settle();
		chk(8'(term[3]), 8'h00);
		@(posedge mclk_in) cspd <= 1'b1;
		settle();
		chk(8'(term[3]), 8'h01);
		wr_reg(REG_LOC_MODE, LOWCUR_ALWAYS);
		@(posedge mclk_in) cur <= 8'hC8;
		@(posedge mclk_in) rq <= 1'b1;
		settle();
		rd_reg(REG_FLAGS);
		chk(v, 8'h13);
		chk({6'h00, mf, mr}, 8'h00);
		@(posedge mclk_in) fq <= 1'b0;
		rq <= 1'b0;
		settle();
		@(posedge mclk_in) rq <= 1'b1;
		settle();
		rd_reg(REG_FLAGS);
		chk(v, 8'h53);
		chk({6'h00, mf, mr}, 8'h01);
		@(posedge mclk_in) rq <= 1'b0;
		done("run");
		@(posedge mclk_in) fq <= 1'b1;
		settle();
		@(posedge mclk_in) pwr <= 1'b0;
		settle();
		chk({5'h00, term[4], mf, mr}, 8'h00);
		@(posedge mclk_in) pwr <= 1'b1;
		settle();
		chk({5'h00, term[4], mf, mr}, 8'h04);
		@(posedge mclk_in) fq <= 1'b0;
		settle();
		@(posedge mclk_in) fq <= 1'b1;
		settle();
		chk({5'h00, term[4], mf, mr}, 8'h06);
		done("ready");
		for (int i = 0; i < 8; i++) begin
			wr_reg(REG_SEL0, CODES[i]);
			wr_reg(REG_RELAY_SEL, CODES[i]);
			settle();
			chk({6'h00, seen[5], seen[0]}, {6'h00, {2{RUN_FLAGS[i]}}});
		end
		wr_reg(REG_SEL0, CODE_FAN);
		wr_reg(REG_RELAY_SEL, CODE_MAJOR);
		@(posedge mclk_in) fq <= 1'b0;
		done("select");
		// Last table entry is a plain trip that must not count as major
		for (int i = 0; i < 7; i++) begin
			@(posedge mclk_in) tev <= 1'b1;
			tcode <= TRIPS[i];
			tact <= 1'b1;
			@(posedge mclk_in) tev <= 1'b0;
			settle();
			chk({6'h00, relay, term[4]}, (i < 6) ? 8'h02 : 8'h00);
			@(posedge mclk_in) frst <= 1'b1;
			tact <= 1'b0;
			@(posedge mclk_in) frst <= 1'b0;
			settle();
			chk({6'h00, relay, term[4]}, 8'h01);
		end
		done("major");
		chk(8'(irq), 8'h00);
		wr_reg(REG_IRQ_STAT, 8'hFF);
		rd_reg(REG_IRQ_STAT);
		chk(v, 8'h00);
		wr_reg(REG_IRQ_MASK, 8'hFF);
		@(posedge mclk_in) temp <= 8'hC9;
		settle();
		rd_reg(REG_IRQ_STAT);
		chk(v, 8'h04);
		chk(8'(irq), 8'h01);
		wr_reg(REG_IRQ_MASK, 8'hFB);
		settle();
		chk(8'(irq), 8'h00);
		wr_reg(REG_IRQ_MASK, 8'hFF);
		wr_reg(REG_IRQ_STAT, 8'h04);
		settle();
		chk(8'(irq), 8'h00);
		wr_reg(REG_FLAGS, 8'h00);
		rd_reg(REG_FLAGS);
		chk(v, 8'h15);
		done("irq");
		// Terminal command still counts as start contact under software control
		wr_reg(REG_RUN_SRC, RUN_SRC_REG);
		@(posedge mclk_in) fq <= 1'b1;
		settle();
		chk({5'h00, term[1], mf, mr}, 8'h04);
		wr_reg(REG_SW_CMD, 8'h02);
		@(posedge mclk_in) fq <= 1'b0;
		settle();
		chk({5'h00, term[1], mf, mr}, 8'h05);
		done("source");
		@(posedge mclk_in) reset_n_in <= 1'b0;
		repeat (2) @(posedge mclk_in);
		reset_n_in <= 1'b1;
		@(negedge mclk_in);
		chk({mf | mr, relay, irq, term}, 8'h00);
		settle();
		rd_reg(REG_SW_CMD);
		chk(v, 8'h00);
		chk({5'h00, term[1], mf, mr}, 8'h00);
		done("reset again");
		close_out();
	end
endmodule : drive_status_output_flags_bench
